// ===== rtl/status_led_encoder.sv
// status indicator encoder with apb register access and a level interrupt
module status_led_encoder
   import led_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES, // pattern timebase period in cycles
   parameter int HOLD_CYC = HOLD_CYCLES  // power-up red hold in cycles
)(
   input wire logic pclk,               // controller clock, 50 MHz
   input wire logic presetn,            // async reset, active low
   input wire logic psel,               // apb select
   input wire logic penable,            // apb enable
   input wire logic pwrite,             // apb direction
   input wire logic [7:0] paddr,        // apb byte address
   input wire logic [31:0] pwdata,      // apb write data
   output logic [31:0] prdata,          // apb read data
   output logic pready,                 // apb ready
   output logic pslverr,                // apb error on unmapped address
   input wire logic drive_on,           // drive enabled
   input wire logic watchdog_fault,     // watchdog fault level
   input wire logic major_fault,        // major fault level
   input wire logic boot_wait,          // boot loader waiting for firmware
   input wire logic traj_busy,          // motion core pursuing a trajectory
   input wire logic can_err_limit,      // an error counter is over its limit
   input wire logic can_guard_err,      // heartbeat or node guarding error
   input wire logic can_bus_off,        // can controller bus-off
   input wire logic [1:0] nmt_state,    // network management state code
   input wire logic limit_pos_pin,      // positive travel limit pin
   input wire logic limit_neg_pin,      // negative travel limit pin
   output logic trajectory_active_flag, // busy trajectory status
   output logic drive_red,              // drive_state_indicator red
   output logic drive_green,            // drive_state_indicator green
   output logic motion_red,             // motion_state_indicator red
   output logic motion_green,           // motion_state_indicator green
   output logic network_fault_indicator, // red network fault
   output logic network_state_indicator, // green network state
   output logic irq                     // level interrupt, active high
);
   typedef struct packed {
      logic [CNT_W-1:0] tick_cnt;
      logic [PHASE_W-1:0] phase;
      logic [CNT_W-1:0] hold_cnt;
      logic [2:0] settle;
      seq_t seq;
      logic [CTRL_W-1:0] ctrl;
      logic [EV_W-1:0] istat;
      logic [EV_W-1:0] mask;
      logic traj;
      logic major_q;
      logic wdog_q;
      logic bus_off_q;
      logic d_red;
      logic d_green;
      logic m_red;
      logic m_green;
      logic n_fault;
      logic n_state;
      logic [31:0] rdata;
   } enc_state_t;

   enc_state_t cur;
   enc_state_t next_cur;

   logic limit_pos;
   logic limit_neg;
   logic limit_fault;
   logic can_fault;
   logic tick;
   logic flash;
   logic single_flash;
   logic double_flash;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   logic [31:0] status_word;

   // both limit inputs are pins, so each gets its own synchroniser
   pin_sync u_sync_pos (
      .pclk(pclk),
      .presetn(presetn),
      .pin(limit_pos_pin),
      .level(limit_pos)
   );

   pin_sync u_sync_neg (
      .pclk(pclk),
      .presetn(presetn),
      .pin(limit_neg_pin),
      .level(limit_neg)
   );

   // fault level depends on the motor variant, chosen in the control register
   always_comb begin
      if (cur.ctrl[CTRL_LIMIT_HIGH]) begin
         limit_fault = limit_pos | limit_neg; // see [R9]
      end else begin
         limit_fault = ~limit_pos | ~limit_neg; // see [R9]
      end
   end

   assign can_fault = can_err_limit | can_guard_err | can_bus_off;

   // pattern decode from the shared phase counter, one phase per tick
   assign tick = (cur.tick_cnt == CNT_W'(TICK_CYC - 1)); // see [R12]
   assign flash = cur.phase[0]; // see [R12]
   assign single_flash = (cur.phase == 3'h0); // see [R12]
   assign double_flash = (cur.phase == 3'h0) | (cur.phase == 3'h2); // see [R12]

   // apb decode; zero wait states, so reads are captured in the setup cycle
   assign wr_en = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      case (paddr)
         ADDR_CTRL: mapped = 1'b1;
         ADDR_STATUS: mapped = 1'b1;
         ADDR_INT_STATUS: mapped = 1'b1;
         ADDR_INT_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // live status word, read-only
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_DRIVE_RED] = cur.d_red;
      status_word[ST_DRIVE_GREEN] = cur.d_green;
      status_word[ST_MOTION_RED] = cur.m_red;
      status_word[ST_MOTION_GREEN] = cur.m_green;
      status_word[ST_NET_FAULT] = cur.n_fault;
      status_word[ST_NET_STATE] = cur.n_state;
      status_word[ST_TRAJ] = cur.traj;
      status_word[ST_LIMIT_FAULT] = limit_fault;
      status_word[ST_SEQ +: 2] = cur.seq;
   end

   // interrupt events on rising fault edges and sequence milestones
   always_comb begin
      ev_set = '0;
      ev_set[EV_MAJOR] = major_fault & ~cur.major_q;
      ev_set[EV_WATCHDOG] = watchdog_fault & ~cur.wdog_q;
      ev_set[EV_BUS_OFF] = can_bus_off & ~cur.bus_off_q;
      ev_set[EV_LIMIT] = (cur.seq == SEQ_IDLE) & (cur.settle == SETTLE_CYCLES)
         & cur.ctrl[CTRL_ARM] & ~cur.ctrl[CTRL_PROGRAM] & limit_fault;
      ev_set[EV_RUN] = (cur.seq == SEQ_RED_HOLD)
         & (cur.hold_cnt == CNT_W'(HOLD_CYC - 1));
      ev_clr = '0;
      if (wr_en && paddr == ADDR_INT_STATUS) begin
         ev_clr = pwdata[EV_W-1:0];
      end
   end

   always_comb begin
      next_cur = cur;
      next_cur.major_q = major_fault;
      next_cur.wdog_q = watchdog_fault;
      next_cur.bus_off_q = can_bus_off;

      // free-running timebase, never reset by the pattern in use
      if (tick) begin
         next_cur.tick_cnt = '0; // see [R12]
         next_cur.phase = cur.phase + 3'h1; // see [R12]
      end else begin
         next_cur.tick_cnt = cur.tick_cnt + CNT_W'(1);
      end

      // trajectory flag tracks the motion core every cycle
      next_cur.traj = traj_busy; // see [R2]

      // register writes
      if (wr_en && paddr == ADDR_CTRL) begin
         next_cur.ctrl = pwdata[CTRL_W-1:0];
      end
      if (wr_en && paddr == ADDR_INT_MASK) begin
         next_cur.mask = pwdata[EV_W-1:0];
      end
      // a set in the same cycle as its clear wins
      next_cur.istat = (cur.istat & ~ev_clr) | ev_set;

      // read data captured in setup so it is stable through the access phase
      if (rd_setup) begin
         case (paddr)
            ADDR_CTRL: next_cur.rdata = {{(32 - CTRL_W){1'b0}}, cur.ctrl};
            ADDR_STATUS: next_cur.rdata = status_word;
            ADDR_INT_STATUS: next_cur.rdata = {{(32 - EV_W){1'b0}}, cur.istat};
            ADDR_INT_MASK: next_cur.rdata = {{(32 - EV_W){1'b0}}, cur.mask};
            default: next_cur.rdata = 32'h0000_0000;
         endcase
      end

      // power-up sequence; waits for arm so software can set variant and program
      case (cur.seq)
         SEQ_IDLE: begin
            next_cur.hold_cnt = '0;
            if (cur.settle != SETTLE_CYCLES) begin
               // let the limit synchronisers fill before deciding
               next_cur.settle = cur.settle + 3'h1;
            end else if (cur.ctrl[CTRL_ARM]) begin
               if (!cur.ctrl[CTRL_PROGRAM] && limit_fault) begin
                  next_cur.seq = SEQ_LIMIT_FAULT; // see [R9]
               end else if (!cur.ctrl[CTRL_PROGRAM]) begin
                  next_cur.seq = SEQ_RED_HOLD; // see [R10]
               end else if (cur.ctrl[CTRL_LIMITS_ONLY]) begin
                  next_cur.seq = SEQ_RED_HOLD; // see [R11]
               end else begin
                  next_cur.seq = SEQ_RUN;
               end
            end
         end
         SEQ_LIMIT_FAULT: begin
            // held until the limits leave the fault level
            if (!limit_fault) begin
               next_cur.seq = SEQ_RED_HOLD; // see [R9]
            end
         end
         SEQ_RED_HOLD: begin
            if (cur.hold_cnt == CNT_W'(HOLD_CYC - 1)) begin
               next_cur.seq = SEQ_RUN; // see [R10] [R11]
               next_cur.hold_cnt = '0;
            end else begin
               next_cur.hold_cnt = cur.hold_cnt + CNT_W'(1); // see [R10]
            end
         end
         SEQ_RUN: begin
            next_cur.hold_cnt = '0;
         end
         default: begin
            next_cur.seq = SEQ_IDLE;
         end
      endcase

      // drive and motion indicators by sequence and live state
      case (cur.seq)
         SEQ_IDLE: begin
            // not armed yet reads as no power
            next_cur.d_red = 1'b0;
            next_cur.d_green = 1'b0;
            next_cur.m_red = 1'b0;
            next_cur.m_green = 1'b0;
         end
         SEQ_LIMIT_FAULT, SEQ_RED_HOLD: begin
            next_cur.d_red = 1'b1; // see [R9] [R10] [R11]
            next_cur.d_green = 1'b0;
            next_cur.m_red = 1'b0; // see [R9] [R10] [R11]
            next_cur.m_green = 1'b0;
         end
         SEQ_RUN: begin
            // boot wait outranks faults, faults outrank drive state
            if (boot_wait) begin
               next_cur.d_red = flash; // see [R1]
               next_cur.d_green = ~flash; // see [R1]
            end else if (major_fault) begin
               next_cur.d_red = 1'b1; // see [R1]
               next_cur.d_green = 1'b0;
            end else if (watchdog_fault) begin
               next_cur.d_red = flash; // see [R1]
               next_cur.d_green = 1'b0;
            end else if (drive_on) begin
               next_cur.d_red = 1'b0;
               next_cur.d_green = 1'b1; // see [R1]
            end else begin
               next_cur.d_red = 1'b0;
               next_cur.d_green = flash; // see [R1]
            end
            if (cur.ctrl[CTRL_CAN_OPTION] && can_fault) begin
               if (cur.traj) begin
                  next_cur.m_red = flash; // see [R4]
                  next_cur.m_green = ~flash; // see [R4]
               end else begin
                  next_cur.m_red = flash; // see [R4]
                  next_cur.m_green = 1'b0;
               end
            end else begin
               next_cur.m_red = 1'b0;
               next_cur.m_green = cur.traj; // see [R3]
            end
         end
         default: begin
            next_cur.d_red = 1'b0;
            next_cur.d_green = 1'b0;
            next_cur.m_red = 1'b0;
            next_cur.m_green = 1'b0;
         end
      endcase

      // network fault indicator, most severe condition first
      if (can_bus_off) begin
         next_cur.n_fault = 1'b1; // see [R6]
      end else if (can_guard_err) begin
         next_cur.n_fault = double_flash; // see [R6]
      end else if (can_err_limit) begin
         next_cur.n_fault = single_flash; // see [R5]
      end else begin
         next_cur.n_fault = 1'b0; // see [R5]
      end

      // network state indicator
      case (nmt_state)
         NMT_PREOP: next_cur.n_state = flash; // see [R7]
         NMT_OPER: next_cur.n_state = 1'b1; // see [R7]
         NMT_STOP: next_cur.n_state = single_flash; // see [R8]
         default: next_cur.n_state = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
         cur.seq <= SEQ_IDLE;
         cur.ctrl <= CTRL_RESET;
         cur.istat <= EV_RESET;
         cur.mask <= EV_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // outputs straight from the state register
   assign prdata = cur.rdata;
   assign trajectory_active_flag = cur.traj;
   assign drive_red = cur.d_red;
   assign drive_green = cur.d_green;
   assign motion_red = cur.m_red;
   assign motion_green = cur.m_green;
   assign network_fault_indicator = cur.n_fault;
   assign network_state_indicator = cur.n_state;
   assign irq = |(cur.istat & cur.mask);
endmodule

// ===== pkg/led_pkg.sv
// Operation
// [R1] drive indicator: solid green on, flash green off, flash red watchdog, red major, alt boot
// [R2] trajectory flag follows whether the motor is pursuing a trajectory
// [R3] motion indicator off when flag clear, green when set, bus healthy
// [R4] with can option, bus fault: flash red flag clear, alternate when set
// [R5] network fault indicator off without error, single flash on counter limit
// [R6] network fault indicator double flash on heartbeat or guard error, solid bus-off
// [R7] network state indicator blinks pre-operational, solid when operational
// [R8] network state indicator single flash when stopped
// [R9] no program and limits at fault level: drive solid red, motion off
// [R10] no program, limits fine: solid red 500 ms then flash green, motion off
// [R11] program disabling only limits: same red hold then flash green
// [R12] all patterns come from one free-running prescaled timebase
package led_pkg;
   // apb register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
   // control fields
   localparam int CTRL_ARM = 0;
   localparam int CTRL_LIMIT_HIGH = 1;
   localparam int CTRL_PROGRAM = 2;
   localparam int CTRL_LIMITS_ONLY = 3;
   localparam int CTRL_CAN_OPTION = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   // status fields
   localparam int ST_DRIVE_RED = 0;
   localparam int ST_DRIVE_GREEN = 1;
   localparam int ST_MOTION_RED = 2;
   localparam int ST_MOTION_GREEN = 3;
   localparam int ST_NET_FAULT = 4;
   localparam int ST_NET_STATE = 5;
   localparam int ST_TRAJ = 6;
   localparam int ST_LIMIT_FAULT = 7;
   localparam int ST_SEQ = 8;
   // interrupt fields
   localparam int EV_LIMIT = 0;
   localparam int EV_MAJOR = 1;
   localparam int EV_WATCHDOG = 2;
   localparam int EV_BUS_OFF = 3;
   localparam int EV_RUN = 4;
   localparam int EV_W = 5;
   localparam logic [EV_W-1:0] EV_RESET = 5'h00;
   // network management state codes on the nmt_state input
   localparam logic [1:0] NMT_INIT = 2'h0;
   localparam logic [1:0] NMT_PREOP = 2'h1;
   localparam logic [1:0] NMT_OPER = 2'h2;
   localparam logic [1:0] NMT_STOP = 2'h3;
   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 200;
   localparam int HOLD_MS = 500;
   localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
   localparam int HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 25;
   localparam int PHASE_W = 3;
   // limit synchroniser settle time before the power-up decision
   localparam logic [2:0] SETTLE_CYCLES = 3'h6;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_LIMIT_FAULT, SEQ_RED_HOLD, SEQ_RUN} seq_t;
endpackage

// ===== rtl/pin_sync.sv
// three-stage synchroniser, output moves only when stages two and three agree
module pin_sync
   import led_pkg::*;
(
   input wire logic pclk,    // controller clock
   input wire logic presetn, // async reset, active low
   input wire logic pin,     // asynchronous pin level
   output logic level        // filtered level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sync_state_t;

   sync_state_t cur;
   sync_state_t next_cur;

   // s1 feeds s2 only; the agreement check looks at s2 and s3
   always_comb begin
      next_cur = cur;
      next_cur.s1 = pin;
      next_cur.s2 = cur.s1;
      next_cur.s3 = cur.s2;
      if (cur.s2 == cur.s3) begin
         next_cur.level = cur.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign level = cur.level;
endmodule

// ===== dv/led_chk.sv
module led_chk
   import led_pkg::*;
(
   input wire logic pclk, // controller clock
   input wire logic presetn, // async reset, active low
   input wire logic major_fault, // major fault level
   input wire logic boot_wait, // boot loader waiting
   input wire logic traj_busy, // trajectory in progress
   input wire logic can_err_limit, // error counter over limit
   input wire logic can_guard_err, // heartbeat or guard error
   input wire logic can_bus_off, // bus-off
   input wire logic [1:0] nmt_state, // network state code
   input wire logic trajectory_active_flag, // busy flag
   input wire logic drive_red, // drive lamp red
   input wire logic drive_green, // drive lamp green
   input wire logic motion_red, // motion lamp red
   input wire logic motion_green, // motion lamp green
   input wire logic network_fault_indicator, // network fault lamp
   input wire logic network_state_indicator // network state lamp
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a two-colour lamp alternates, it never mixes both colours
   drive_alt_a: assert property (!(drive_red && drive_green))
      else $error("drive lamp lit in both colours");
   major_red_a: assert property (
      $past(major_fault) && !$past(boot_wait) |-> !drive_green)
      else $error("drive lamp green during a major fault");
   traj_flag_a: assert property (trajectory_active_flag == $past(traj_busy))
      else $error("busy flag does not follow the trajectory");
   // motion green needs a trajectory, two cycles back through the flag
   motion_grn_a: assert property (motion_green |-> $past(traj_busy, 2))
      else $error("motion lamp green without a trajectory");
   motion_red_a: assert property (motion_red |->
      $past(can_err_limit || can_guard_err || can_bus_off))
      else $error("motion lamp red without a bus fault");
   motion_alt_a: assert property (!(motion_red && motion_green))
      else $error("motion lamp lit in both colours");
   net_quiet_a: assert property (
      !$past(can_err_limit || can_guard_err || can_bus_off) |-> !network_fault_indicator)
      else $error("network fault lamp lit without error");
   bus_off_a: assert property ($past(can_bus_off) |-> network_fault_indicator)
      else $error("network fault lamp dark while bus-off");
   net_oper_a: assert property (
      $past(nmt_state) == NMT_OPER |-> network_state_indicator)
      else $error("network state lamp dark while operational");
endmodule

// ===== dv/led_viewer.sv
module led_viewer #(
   parameter int WIN = 32 // one whole pattern frame in cycles
)(
   input wire logic pclk, // controller clock
   input wire logic start, // begin a viewing window
   input wire logic [7:0] lamp, // lamps and flags under watch
   output logic done, // one-cycle pulse, counts valid
   output logic [63:0] cnt // lit cycles per lamp, eight bits each
);
   timeunit 1ns;
   timeprecision 1ns;
   int left;
   // the operator counts lit cycles over a full frame, so any phase gives exact counts
   always_ff @(posedge pclk) begin
      done <= 1'b0;
      if (start) begin
         left <= WIN;
         cnt <= '0;
      end else if (left > 0) begin
         for (int i = 0; i < 8; i++) begin
            cnt[i*8 +: 8] <= cnt[i*8 +: 8] + 8'(lamp[i]);
         end
         left <= left - 1;
         done <= (left == 1);
      end
   end
endmodule

// ===== dv/testbench.sv
module testbench
   import led_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4;
   localparam int HC = 20;
   typedef struct {logic [63:0] e; logic [63:0] m;} note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, start, done;
   logic [7:0] paddr;
   logic [7:0] lf = 8'h59;
   logic [7:0] r;
   logic [31:0] pwdata, prdata;
   logic [63:0] cnt;
   logic drive_on, watchdog_fault, major_fault, boot_wait, traj_busy;
   logic can_err_limit, can_guard_err, can_bus_off, limit_pos_pin, limit_neg_pin;
   logic [1:0] nmt_state;
   logic trajectory_active_flag, drive_red, drive_green, motion_red, motion_green;
   logic network_fault_indicator, network_state_indicator;
   note_t lq[$], rq[$], nt;
   int error_cnt, total_checks;
   // power-up configurations, drive, motion and network tables
   logic [31:0] pu[3] = '{32'h0000_0001, 32'h0000_000D, 32'h0000_0005};
   logic [3:0] dv[8] = '{4'h8, 4'hC, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h0};
   int dr[8] = '{16, 16, 32, 32, 16, 16, 0, 0};
   int dg[8] = '{16, 16, 0, 0, 0, 0, 32, 16};
   logic [3:0] mv[6] = '{4'h0, 4'h8, 4'h4, 4'hA, 4'h9, 4'hC};
   int mr[6] = '{0, 0, 16, 16, 16, 0};
   int mg[6] = '{0, 32, 0, 16, 16, 32};
   logic [4:0] nv[5] = '{5'h00, 5'h11, 5'h0A, 5'h07, 5'h19};
   int nf[5] = '{0, 4, 8, 32, 8};
   int ns[5] = '{0, 16, 32, 4, 16};

   status_led_encoder #(.TICK_CYC(TK), .HOLD_CYC(HC)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_on(drive_on),
      .watchdog_fault(watchdog_fault), .major_fault(major_fault), .boot_wait(boot_wait),
      .traj_busy(traj_busy), .can_err_limit(can_err_limit), .can_guard_err(can_guard_err),
      .can_bus_off(can_bus_off), .nmt_state(nmt_state), .limit_pos_pin(limit_pos_pin),
      .limit_neg_pin(limit_neg_pin), .trajectory_active_flag(trajectory_active_flag),
      .drive_red(drive_red), .drive_green(drive_green), .motion_red(motion_red),
      .motion_green(motion_green), .network_fault_indicator(network_fault_indicator),
      .network_state_indicator(network_state_indicator), .irq(irq));
   led_viewer #(.WIN(32)) u_view (.pclk(pclk), .start(start), .done(done), .cnt(cnt),
      .lamp({trajectory_active_flag, irq, network_state_indicator, network_fault_indicator,
      motion_green, motion_red, drive_green, drive_red}));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   function automatic logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction

   task automatic chk(input string w, input logic [63:0] e, s, m);
      total_checks++;
      if ((s & m) !== (e & m)) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", w, e & m, s & m);
      end
   endtask

   // results are settled by the falling edge, away from the launching edge
   always @(negedge pclk) begin
      if (done === 1'b1 && lq.size() > 0) begin
         nt = lq.pop_front();
         chk("lamp counts", nt.e, cnt, nt.m);
      end
   end

   // read data is taken at the edge that completes the access, as the master would
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && rq.size() > 0) begin
         nt = rq.pop_front();
         chk("read word", nt.e, {31'h0, pslverr, prdata}, nt.m);
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [63:0] e, m);
      rq.push_back('{e, m});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // a negative count leaves that lamp unchecked
   task automatic arm_view(input int lo, input int c0, c1, c2, c3);
      int c[4];
      note_t x;
      c = '{c0, c1, c2, c3};
      x.e = '0;
      x.m = '0;
      for (int i = 0; i < 4; i++) begin
         if (c[i] >= 0) begin
            x.e[(lo + i) * 8 +: 8] = 8'(c[i]);
            x.m[(lo + i) * 8 +: 8] = 8'hFF;
         end
      end
      lq.push_back(x);
      @(posedge pclk);
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
   endtask

   task automatic wait_done();
      do @(negedge pclk); while (done !== 1'b1);
      @(posedge pclk);
   endtask

   task automatic view(input int lo, input int c0, c1, c2, c3);
      repeat (3) @(posedge pclk);
      arm_view(lo, c0, c1, c2, c3);
      wait_done();
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      {boot_wait, major_fault, watchdog_fault, drive_on, traj_busy} <= '0;
      {can_err_limit, can_guard_err, can_bus_off, nmt_state} <= '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // a hang counts as a mismatch; the tests need well under this
   initial begin
      #400_000;
      error_cnt++;
      $display("watchdog ran out");
      give_verdict();
   end

   initial begin
      {psel, penable, pwrite, start} = '0;
      paddr = '0;
      pwdata = '0;
      limit_pos_pin = 1'b1;
      limit_neg_pin = 1'b0;
      do_reset();
      traj_busy <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      rd(ADDR_CTRL, 64'h0000_0000_0000_0003, 64'h0000_0000_0000_001F);
      view(0, 32, 0, 0, 0);
      view(4, -1, -1, 0, 32);
      rd(ADDR_STATUS, 64'h0000_0000_0000_01C1, 64'h0000_0000_0000_03FF);
      rd(ADDR_INT_STATUS, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001);
      apb(1'b1, ADDR_INT_MASK, 32'h0000_0001);
      rd(ADDR_INT_MASK, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_001F);
      view(4, -1, -1, 32, -1);
      apb(1'b1, ADDR_INT_STATUS, 32'h0000_0001);
      view(4, -1, -1, 0, -1);
      rd(8'h10, 64'h0000_0001_0000_0000, 64'h0000_0001_FFFF_FFFF);
      $display("test limit fault finished");
      // limits at the non-fault level, three kinds of start-up
      limit_neg_pin <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         do_reset();
         arm_view(0, (k < 2) ? HC : 0, -1, 0, 0);
         apb(1'b1, ADDR_CTRL, pu[k]);
         wait_done();
         rd(ADDR_INT_STATUS, (k < 2) ? 64'h10 : 64'h0, 64'h0000_0000_0000_0010);
      end
      $display("test red hold finished");
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         {boot_wait, major_fault, watchdog_fault, drive_on} <= dv[k];
         {can_err_limit, can_guard_err, can_bus_off, nmt_state} <= r[4:0];
         view(0, dr[k], dg[k], -1, -1);
      end
      $display("test drive lamp finished");
      apb(1'b1, ADDR_CTRL, 32'h0000_0015);
      for (int k = 0; k < 6; k++) begin
         if (k == 5) apb(1'b1, ADDR_CTRL, 32'h0000_0005);
         r = rnd();
         {traj_busy, can_err_limit, can_guard_err, can_bus_off} <= mv[k];
         {boot_wait, major_fault, watchdog_fault, drive_on} <= r[3:0];
         view(0, -1, -1, mr[k], mg[k]);
      end
      $display("test motion lamp finished");
      for (int k = 0; k < 5; k++) begin
         r = rnd();
         {can_err_limit, can_guard_err, can_bus_off, nmt_state} <= nv[k];
         {boot_wait, major_fault, watchdog_fault, drive_on, traj_busy} <= r[4:0];
         view(4, nf[k], ns[k], -1, -1);
      end
      $display("test network lamps finished");
      give_verdict();
   end
endmodule

bind status_led_encoder led_chk u_chk (.pclk(pclk), .presetn(presetn),
   .major_fault(major_fault), .boot_wait(boot_wait), .traj_busy(traj_busy),
   .can_err_limit(can_err_limit), .can_guard_err(can_guard_err), .can_bus_off(can_bus_off),
   .nmt_state(nmt_state), .trajectory_active_flag(trajectory_active_flag),
   .drive_red(drive_red), .drive_green(drive_green), .motion_red(motion_red),
   .motion_green(motion_green), .network_fault_indicator(network_fault_indicator),
   .network_state_indicator(network_state_indicator));
